// ---- bladp_pkg.sv ----
// package: timing constants and command encodings for the dram port controller
package bladp_pkg;
   // clock
   localparam int CLK_PERIOD_PS = 8000;
   // power-up pause and initial refresh burst
   localparam int POWERUP_WAIT_US = 200;
   localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_US * 1000000) / CLK_PERIOD_PS;
   localparam int INIT_REFRESH_COUNT = 8;
   // refresh period for all rows
   localparam int REFRESH_PERIOD_MS = 8;
   localparam int REFRESH_ROWS = 512;
   localparam int REFRESH_INTERVAL_CYC = REFRESH_PERIOD_MS * 1000000 / REFRESH_ROWS * 1000 / CLK_PERIOD_PS;
   // strobe timing in picoseconds (slowest speed grade)
   localparam int ROW_PRECHARGE_PS = 70000;
   localparam int ROW_PULSE_WIDTH_PS = 100000;
   localparam int COLUMN_PULSE_WIDTH_PS = 25000;
   localparam int ROW_TO_COLUMN_DELAY_PS = 25000;
   localparam int COLUMN_ADDRESS_HOLD_PS = 20000;
   localparam int REFRESH_COLUMN_SETUP_PS = 10000;
   localparam int REFRESH_COLUMN_HOLD_PS = 30000;
   localparam int COLUMN_TO_WRITE_DELAY_PS = 60000;
   localparam int WRITE_TO_COLUMN_LEAD_PS = 25000;
   localparam int DATA_HOLD_PS = 20000;
   // least times round up to whole cycles
   function automatic int min_cycles(input int ps);
      int c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : min_cycles
   localparam int ROW_PRECHARGE_CYC = min_cycles(ROW_PRECHARGE_PS);
   localparam int ROW_PULSE_WIDTH_CYC = min_cycles(ROW_PULSE_WIDTH_PS);
   localparam int COLUMN_PULSE_WIDTH_CYC = min_cycles(COLUMN_PULSE_WIDTH_PS);
   localparam int ROW_TO_COLUMN_DELAY_CYC = min_cycles(ROW_TO_COLUMN_DELAY_PS);
   localparam int COLUMN_ADDRESS_HOLD_CYC = min_cycles(COLUMN_ADDRESS_HOLD_PS);
   localparam int REFRESH_COLUMN_SETUP_CYC = min_cycles(REFRESH_COLUMN_SETUP_PS);
   localparam int REFRESH_COLUMN_HOLD_CYC = min_cycles(REFRESH_COLUMN_HOLD_PS);
   localparam int COLUMN_TO_WRITE_DELAY_CYC = min_cycles(COLUMN_TO_WRITE_DELAY_PS);
   localparam int WRITE_TO_COLUMN_LEAD_CYC = min_cycles(WRITE_TO_COLUMN_LEAD_PS);
   localparam int DATA_HOLD_CYC = min_cycles(DATA_HOLD_PS);
   // geometry
   localparam int ADDR_PIN_W = 9;
   localparam int DATA_W = 16;
   localparam int FIFO_DEPTH = 32;
   // request commands
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_RMW = 2'h2;
   // strobe idle level
   localparam logic STROBE_IDLE = 1'h1;
endpackage : bladp_pkg

// ---- bladp_fifo.sv ----
// file: synchronous valid/ready fifo for write data
`timescale 1ns/100ps
`default_nettype none
module bladp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH]; // storage array
   logic [AW-1:0] wr_ptr_q; // write index
   logic [AW-1:0] rd_ptr_q; // read index
   logic [AW:0] count_q; // fill level, one bit wider for full
   logic push; // accepted write
   logic pop; // accepted read

   // honest flags straight from the fill level
   assign in_ready_o = (count_q != (AW+1)'(DEPTH));
   assign out_valid_o = (count_q != '0);
   assign out_data_o = mem_q[rd_ptr_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // storage, no reset needed on data
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // pointers and level
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
         end
         case ({push, pop})
            2'b10: count_q <= count_q + (AW+1)'(1);
            2'b01: count_q <= count_q - (AW+1)'(1);
            default: count_q <= count_q;
         endcase
      end
   end
endmodule : bladp_fifo
`default_nettype wire

// ---- bladp_timer.sv ----
// file: loadable down counter used for strobe interval timing
`timescale 1ns/100ps
`default_nettype none
module bladp_timer #(
   parameter int WIDTH = 16
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic load_i,
   input wire logic [WIDTH-1:0] value_i,
   output logic done_o
);
   logic [WIDTH-1:0] count_q; // remaining cycles

   // load wins over counting; stops at zero
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_q <= '0;
      end else if (load_i) begin
         count_q <= value_i;
      end else if (count_q != '0) begin
         count_q <= count_q - WIDTH'(1);
      end
   end

   // done from the count alone, so the load that it causes cannot loop back
   assign done_o = (count_q == '0);
endmodule : bladp_timer
`default_nettype wire

// ---- bladp_ctrl.sv ----
// file: host controller driving the strobe-multiplexed 256k x 16 dram port
`timescale 1ns/100ps
`default_nettype none
module bladp_ctrl #(
   parameter int POWERUP_WAIT_CYC = bladp_pkg::POWERUP_WAIT_CYC,
   parameter int REFRESH_INTERVAL_CYC = bladp_pkg::REFRESH_INTERVAL_CYC,
   parameter int INIT_REFRESH_COUNT = bladp_pkg::INIT_REFRESH_COUNT,
   parameter int FIFO_DEPTH = bladp_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic reset_i,
   // user request side
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic [1:0] req_cmd_i,
   input wire logic [17:0] req_addr_i,
   input wire logic [1:0] req_lanes_i,
   // user write data stream
   input wire logic wdata_valid_i,
   output logic wdata_ready_o,
   input wire logic [15:0] wdata_i,
   // user read answer
   output logic rdata_valid_o,
   output logic [15:0] rdata_o,
   output logic init_done_o,
   // device pins
   output logic row_strobe_n_o,
   output logic lower_column_strobe_n_o,
   output logic upper_column_strobe_n_o,
   output logic write_enable_n_o,
   output logic output_enable_n_o,
   output logic [8:0] address_pins_o,
   input wire logic [15:0] data_pins_i,
   output logic [15:0] data_pins_o,
   output logic data_pins_oe_o
);
   localparam int TW = 32;

   // controller states, gray along the rmw access path
   typedef enum logic [3:0] {
      ST_POWERUP = 4'h0,
      ST_IDLE = 4'h1,
      ST_ROW = 4'h3,
      ST_COL = 4'h2,
      ST_WRITE = 4'h6,
      ST_RELEASE = 4'h7,
      ST_PRECHARGE = 4'h5,
      ST_REF_SETUP = 4'h4,
      ST_REF_ROW = 4'hC,
      ST_REF_HOLD = 4'hD
   } bladp_state_e;

   bladp_state_e state_q; // current phase
   logic timer_load; // restart interval timer
   logic [TW-1:0] timer_value; // cycles for next phase
   logic timer_done; // interval elapsed
   logic [TW-1:0] refresh_cnt_q; // refresh interval counter
   logic refresh_due_q; // a refresh is owed
   logic [3:0] init_left_q; // initial refreshes still owed
   logic init_done_q; // power-up sequence finished
   logic [1:0] cmd_q; // latched command
   logic [8:0] col_q; // latched column
   logic [1:0] lanes_q; // latched byte lanes, bit0 lower
   logic [15:0] wdata_q; // latched write word
   logic [15:0] din_sync1_q; // first synchroniser stage
   logic [15:0] din_sync2_q; // second synchroniser stage
   logic fifo_valid; // fifo holds a word
   logic [15:0] fifo_data; // fifo head
   logic fifo_pop; // fifo word taken
   logic needs_data; // request is a write or rmw
   logic start_access; // request accepted this cycle

   // write data stream buffered ahead of the pins
   bladp_fifo #(
      .WIDTH(bladp_pkg::DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_valid_i(wdata_valid_i),
      .in_ready_o(wdata_ready_o),
      .in_data_i(wdata_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data)
   );

   // one timer serves every strobe interval, since phases never overlap
   bladp_timer #(
      .WIDTH(TW)
   ) u_timer (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .load_i(timer_load),
      .value_i(timer_value),
      .done_o(timer_done)
   );

   // write-type requests stall until their data word is in the fifo
   assign needs_data = (req_cmd_i != bladp_pkg::CMD_READ);
   assign start_access = (state_q == ST_IDLE) && init_done_q && !refresh_due_q && req_valid_i
                         && (!needs_data || fifo_valid);
   assign fifo_pop = start_access && needs_data;
   assign req_ready_o = start_access;

   // data pins come from outside the clock domain: two stages before use
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         din_sync1_q <= 16'h0000;
         din_sync2_q <= 16'h0000;
      end else begin
         din_sync1_q <= data_pins_i;
         din_sync2_q <= din_sync1_q;
      end
   end

   // refresh interval: one row owed every interval, counter rows inside device
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         refresh_cnt_q <= '0;
         refresh_due_q <= 1'b0;
      end else begin
         if (refresh_cnt_q >= TW'(REFRESH_INTERVAL_CYC - 1)) begin
            refresh_cnt_q <= '0;
         end else begin
            refresh_cnt_q <= refresh_cnt_q + TW'(1);
         end
         // set wins over clear when both land together
         if (refresh_cnt_q >= TW'(REFRESH_INTERVAL_CYC - 1)) begin
            refresh_due_q <= 1'b1;
         end else if (state_q == ST_REF_SETUP) begin
            refresh_due_q <= 1'b0;
         end
      end
   end

   // timer loads on every phase change except those into idle
   always_comb begin
      timer_load = 1'b0;
      timer_value = '0;
      case (state_q)
         ST_IDLE: begin
            if (init_done_q && refresh_due_q) begin
               timer_load = 1'b1;
               timer_value = TW'(bladp_pkg::REFRESH_COLUMN_SETUP_CYC);
            end else if (start_access) begin
               timer_load = 1'b1;
               timer_value = TW'(bladp_pkg::ROW_TO_COLUMN_DELAY_CYC);
            end else if (!init_done_q && init_left_q != 4'h0) begin
               timer_load = 1'b1;
               timer_value = TW'(bladp_pkg::REFRESH_COLUMN_SETUP_CYC);
            end
         end
         ST_ROW: if (timer_done) begin
            timer_load = 1'b1;
            timer_value = TW'(bladp_pkg::ROW_PULSE_WIDTH_CYC);
         end
         ST_COL: if (timer_done) begin
            timer_load = 1'b1;
            timer_value = TW'(bladp_pkg::WRITE_TO_COLUMN_LEAD_CYC);
         end
         ST_WRITE: if (timer_done) begin
            timer_load = 1'b1;
            timer_value = TW'(bladp_pkg::ROW_PRECHARGE_CYC);
         end
         ST_RELEASE, ST_REF_HOLD: if (timer_done) begin
            timer_load = 1'b1;
            timer_value = TW'(bladp_pkg::ROW_PRECHARGE_CYC);
         end
         ST_REF_SETUP: if (timer_done) begin
            timer_load = 1'b1;
            timer_value = TW'(bladp_pkg::REFRESH_COLUMN_HOLD_CYC);
         end
         ST_REF_ROW: if (timer_done) begin
            timer_load = 1'b1;
            timer_value = TW'(bladp_pkg::ROW_PULSE_WIDTH_CYC);
         end
         ST_POWERUP: if (timer_done) begin
            timer_load = 1'b1;
            timer_value = TW'(bladp_pkg::ROW_PRECHARGE_CYC);
         end
         default: begin
            timer_load = 1'b0;
            timer_value = '0;
         end
      endcase
   end

   // sequencer; the power-up wait has its own counter as it is long
   logic [TW-1:0] powerup_cnt_q; // cycles waited since reset
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= ST_POWERUP;
         powerup_cnt_q <= '0;
         init_left_q <= 4'(INIT_REFRESH_COUNT);
         init_done_q <= 1'b0;
         cmd_q <= bladp_pkg::CMD_READ;
         col_q <= 9'h000;
         lanes_q <= 2'h0;
         wdata_q <= 16'h0000;
      end else begin
         case (state_q)
            // strobes stay high throughout the pause
            ST_POWERUP: begin
               if (powerup_cnt_q >= TW'(POWERUP_WAIT_CYC - 1)) begin
                  state_q <= ST_IDLE;
               end else begin
                  powerup_cnt_q <= powerup_cnt_q + TW'(1);
               end
            end
            ST_IDLE: begin
               if (init_done_q && refresh_due_q) begin
                  state_q <= ST_REF_SETUP;
               end else if (start_access) begin
                  cmd_q <= req_cmd_i;
                  col_q <= req_addr_i[8:0];
                  lanes_q <= req_lanes_i;
                  wdata_q <= fifo_data;
                  state_q <= ST_ROW;
               end else if (!init_done_q && init_left_q != 4'h0) begin
                  state_q <= ST_REF_SETUP;
               end
            end
            ST_ROW: if (timer_done) state_q <= ST_COL;
            // read data sampled at end of the column phase, before the column strobes rise, long after access time
            ST_COL: if (timer_done) begin
               state_q <= (cmd_q == bladp_pkg::CMD_RMW) ? ST_WRITE : ST_RELEASE;
            end
            ST_WRITE: if (timer_done) state_q <= ST_RELEASE;
            ST_RELEASE: if (timer_done) state_q <= ST_PRECHARGE;
            ST_PRECHARGE: if (timer_done) state_q <= ST_IDLE;
            ST_REF_SETUP: if (timer_done) state_q <= ST_REF_ROW;
            ST_REF_ROW: if (timer_done) state_q <= ST_REF_HOLD;
            ST_REF_HOLD: if (timer_done) begin
               state_q <= ST_PRECHARGE;
               if (!init_done_q) begin
                  init_left_q <= init_left_q - 4'h1;
                  init_done_q <= (init_left_q == 4'h1);
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // device pin drive; all pins registered
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         row_strobe_n_o <= bladp_pkg::STROBE_IDLE;
         lower_column_strobe_n_o <= bladp_pkg::STROBE_IDLE;
         upper_column_strobe_n_o <= bladp_pkg::STROBE_IDLE;
         write_enable_n_o <= 1'b1;
         output_enable_n_o <= 1'b1;
         address_pins_o <= 9'h000;
         data_pins_o <= 16'h0000;
         data_pins_oe_o <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start_access) begin
                  // row latched with both column strobes high
                  address_pins_o <= req_addr_i[17:9];
                  row_strobe_n_o <= 1'b0;
                  // early write: enable low before the column strobe
                  write_enable_n_o <= (req_cmd_i != bladp_pkg::CMD_WRITE);
                  output_enable_n_o <= (req_cmd_i == bladp_pkg::CMD_WRITE);
                  data_pins_o <= fifo_data;
                  data_pins_oe_o <= (req_cmd_i == bladp_pkg::CMD_WRITE);
               end else if ((init_done_q && refresh_due_q) || (!init_done_q && init_left_q != 4'h0)) begin
                  // column before row: both strobes low, write-enable high
                  lower_column_strobe_n_o <= 1'b0;
                  upper_column_strobe_n_o <= 1'b0;
                  write_enable_n_o <= 1'b1;
               end
            end
            ST_ROW: if (timer_done) begin
               // column switched in on the same edge as the column strobes fall
               address_pins_o <= col_q;
               lower_column_strobe_n_o <= !lanes_q[0];
               upper_column_strobe_n_o <= !lanes_q[1];
            end
            ST_COL: if (timer_done && cmd_q == bladp_pkg::CMD_RMW) begin
               // late write after output sampled: drop output enable and drive on the same edge
               output_enable_n_o <= 1'b1;
               write_enable_n_o <= 1'b0;
               data_pins_o <= wdata_q;
               data_pins_oe_o <= 1'b1;
            end
            ST_REF_SETUP: if (timer_done) row_strobe_n_o <= 1'b0;
            ST_REF_ROW: if (timer_done) begin
               lower_column_strobe_n_o <= 1'b1;
               upper_column_strobe_n_o <= 1'b1;
            end
            ST_RELEASE, ST_REF_HOLD: if (timer_done) begin
               // all strobes driven high here (after a refresh the column strobes are already high); write enable and data drive held until the precharge phase ends
               row_strobe_n_o <= 1'b1;
               lower_column_strobe_n_o <= 1'b1;
               upper_column_strobe_n_o <= 1'b1;
               output_enable_n_o <= 1'b1;
            end
            ST_PRECHARGE: if (timer_done) begin
               write_enable_n_o <= 1'b1;
               data_pins_oe_o <= 1'b0;
            end
            default: begin
               row_strobe_n_o <= row_strobe_n_o;
            end
         endcase
      end
   end

   // read answer: captured at the end of the column phase, while the column strobes are still low
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_valid_o <= 1'b0;
         rdata_o <= 16'h0000;
         init_done_o <= 1'b0;
      end else begin
         init_done_o <= init_done_q;
         rdata_valid_o <= (state_q == ST_COL) && timer_done && (cmd_q != bladp_pkg::CMD_WRITE);
         if ((state_q == ST_COL) && timer_done) begin
            // unselected lanes read as zero
            rdata_o <= din_sync2_q & {{8{lanes_q[1]}}, {8{lanes_q[0]}}};
         end
      end
   end
endmodule : bladp_ctrl
`default_nettype wire

// ---- bladp_dram_model.sv ----
// partner: behavioural 256k x 16 dram answering the controller's strobes
`timescale 1ns/100ps
`default_nettype none
module bladp_dram_model (
   input wire logic row_n_i,
   input wire logic lcol_n_i,
   input wire logic ucol_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic [8:0] addr_i,
   input wire logic [15:0] din_i,
   input wire logic din_en_i,
   output logic [15:0] dq_o
);
   logic [15:0] cells [logic [17:0]]; // sparse cell array, unwritten reads zero
   logic [8:0] row_q = 9'h000; // open row
   logic [8:0] refr_row_q = 9'h000; // internal refresh row
   logic [17:0] loc_q = 18'h00000; // selected location
   logic [15:0] word_q = 16'h0000; // selected word
   logic read_q = 1'b0; // write-enable was high at column fall
   int refresh_count = 0; // refreshes seen, read by the bench
   wire col_n = lcol_n_i & ucol_n_i;
   wire [15:0] on = {{8{read_q & ~ucol_n_i & ~oe_n_i}}, {8{read_q & ~lcol_n_i & ~oe_n_i}}};
   // released lanes show the inverse, so a stale sample cannot pass
   assign dq_o = (word_q & on) | (~word_q & ~on);
   // store strobed lanes; a lane the host does not drive becomes unknown
   task automatic store();
      for (int b = 0; b < 16; b++) if (!(b < 8 ? lcol_n_i : ucol_n_i)) word_q[b] = din_en_i ? din_i[b] : 1'hX;
      cells[loc_q] = word_q;
   endtask : store
   // row latch, or internal refresh when a column strobe leads
   always @(negedge row_n_i) begin
      #1;
      if (!col_n) begin
         refr_row_q = refr_row_q + 9'h001;
         refresh_count++;
      end else row_q = addr_i;
   end
   // column latch at the earlier strobe; early write stores at once
   always @(negedge col_n) begin
      #1;
      if (!row_n_i) begin
         loc_q = {row_q, addr_i};
         word_q = cells.exists(loc_q) ? cells[loc_q] : 16'h0000;
         read_q = we_n_i;
         if (!we_n_i) store();
      end
   end
   // late write-enable fall writes over the word being read
   always @(negedge we_n_i) begin
      #1;
      if (!row_n_i && !col_n && read_q) store();
   end
   // outputs released once every column strobe is high
   always @(posedge col_n) read_q = 1'b0;
endmodule : bladp_dram_model
`default_nettype wire

// ---- bladp_ctrl_props.sv ----
// checker: strobe ordering and timing of the dram port controller
`timescale 1ns/100ps
`default_nettype none
module bladp_ctrl_props #(
   parameter int POWERUP_WAIT_CYC = 25000,
   parameter int REFRESH_INTERVAL_CYC = 1953,
   parameter int INIT_REFRESH_COUNT = 8
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic init_done_o,
   input wire logic row_strobe_n_o,
   input wire logic lower_column_strobe_n_o,
   input wire logic upper_column_strobe_n_o,
   input wire logic write_enable_n_o,
   input wire logic [8:0] address_pins_o,
   input wire logic [15:0] data_pins_o,
   input wire logic data_pins_oe_o
);
   wire row_n = row_strobe_n_o;
   wire lo_n = lower_column_strobe_n_o;
   wire col_n = lo_n & upper_column_strobe_n_o; // high while no lane strobed
   int cyc_q, hi_q, lo_q, clo_q, refr_q, since_q; // run lengths and refresh tallies
   wire refr_d = !row_n && hi_q != 0 && !lo_n; // row falls under a low column
   // counters restart on reset so every figure starts at release
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cyc_q <= 0;
         hi_q <= 0;
         lo_q <= 0;
         clo_q <= 0;
         refr_q <= 0;
         since_q <= 0;
      end else begin
         cyc_q <= cyc_q + 1;
         hi_q <= row_n ? hi_q + 1 : 0;
         lo_q <= row_n ? 0 : lo_q + 1;
         clo_q <= lo_n ? 0 : clo_q + 1;
         refr_q <= refr_q + (refr_d ? 1 : 0);
         since_q <= refr_d ? 0 : since_q + 1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   property p_powerup; $fell(row_n) |-> cyc_q >= POWERUP_WAIT_CYC; endproperty
   a_powerup: assert property (p_powerup) else $error("row strobe inside power-up pause");
   property p_init; $fell(row_n) && col_n |-> refr_q >= INIT_REFRESH_COUNT; endproperty
   a_init: assert property (p_init) else $error("access before initial refreshes");
   property p_precharge; $fell(row_n) |-> hi_q >= bladp_pkg::ROW_PRECHARGE_CYC; endproperty
   a_precharge: assert property (p_precharge) else $error("row precharge too short");
   property p_row_pulse; $rose(row_n) |-> lo_q >= bladp_pkg::ROW_PULSE_WIDTH_CYC; endproperty
   a_row_pulse: assert property (p_row_pulse) else $error("row pulse cut short");
   property p_col_hold; $fell(col_n) && !row_n |=> $stable(address_pins_o) [*3]; endproperty
   a_col_hold: assert property (p_col_hold) else $error("column address not held");
   property p_wdata;
      (($fell(col_n) && !write_enable_n_o) || ($fell(write_enable_n_o) && !col_n)) && !row_n
         |-> data_pins_oe_o ##1 (data_pins_oe_o && $stable(data_pins_o)) [*3];
   endproperty
   a_wdata: assert property (p_wdata) else $error("write data not valid or not held");
   property p_refr_setup; $fell(row_n) && !lo_n |-> clo_q >= bladp_pkg::REFRESH_COLUMN_SETUP_CYC; endproperty
   a_refr_setup: assert property (p_refr_setup) else $error("refresh column setup too short");
   property p_refr_due; init_done_o |-> since_q < REFRESH_INTERVAL_CYC + 64; endproperty
   a_refr_due: assert property (p_refr_due) else $error("refresh overdue");
endmodule : bladp_ctrl_props
bind bladp_ctrl bladp_ctrl_props #(.POWERUP_WAIT_CYC(POWERUP_WAIT_CYC),
   .REFRESH_INTERVAL_CYC(REFRESH_INTERVAL_CYC), .INIT_REFRESH_COUNT(INIT_REFRESH_COUNT)) u_props (
   .clk_i(clk_i), .reset_i(reset_i), .init_done_o(init_done_o), .row_strobe_n_o(row_strobe_n_o),
   .lower_column_strobe_n_o(lower_column_strobe_n_o), .upper_column_strobe_n_o(upper_column_strobe_n_o),
   .write_enable_n_o(write_enable_n_o), .address_pins_o(address_pins_o), .data_pins_o(data_pins_o),
   .data_pins_oe_o(data_pins_oe_o));
`default_nettype wire

// ---- byte_lane_async_dram_port_bench.sv ----
// testbench: random byte-lane traffic through the controller against a behavioural memory
`timescale 1ns/100ps
`default_nettype none
module byte_lane_async_dram_port_bench;
   logic clk_i = 1'b0, reset_i = 1'b1, req_valid_i = 1'b0, wdata_valid_i = 1'b0;
   logic [1:0] req_cmd_i = 2'h0, req_lanes_i = 2'h3, cmd;
   logic [17:0] req_addr_i = 18'h00000;
   logic [15:0] wdata_i = 16'h0000, rdata_o, dq_out, mem_dq;
   logic req_ready_o, wdata_ready_o, rdata_valid_o, init_done_o, row_n, lcol_n, ucol_n, we_n, oe_n, dq_oe;
   logic [8:0] addr;
   wire [15:0] dq_in = dq_oe ? dq_out : mem_dq; // shared data pins
   logic [15:0] exp_mem [logic [17:0]]; // expected contents
   logic [15:0] wq [$]; // words waiting in the fifo, in order
   logic [17:0] pool [8]; // few addresses so reads hit earlier writes
   int seed, n_errors = 0, n_checks = 0, i;
   // power-up and refresh counts shortened for simulation
   bladp_ctrl #(.POWERUP_WAIT_CYC(50), .REFRESH_INTERVAL_CYC(200)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i),
      .req_lanes_i(req_lanes_i), .wdata_valid_i(wdata_valid_i), .wdata_ready_o(wdata_ready_o), .wdata_i(wdata_i),
      .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o), .init_done_o(init_done_o), .row_strobe_n_o(row_n),
      .lower_column_strobe_n_o(lcol_n), .upper_column_strobe_n_o(ucol_n), .write_enable_n_o(we_n),
      .output_enable_n_o(oe_n), .address_pins_o(addr), .data_pins_i(dq_in), .data_pins_o(dq_out),
      .data_pins_oe_o(dq_oe));
   bladp_dram_model u_mem (.row_n_i(row_n), .lcol_n_i(lcol_n), .ucol_n_i(ucol_n), .we_n_i(we_n), .oe_n_i(oe_n),
      .addr_i(addr), .din_i(dq_out), .din_en_i(dq_oe), .dq_o(mem_dq));
   initial forever #4 clk_i = ~clk_i;
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      n_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : chk
   function automatic logic [15:0] peek(input logic [17:0] a);
      return exp_mem.exists(a) ? exp_mem[a] : 16'h0000;
   endfunction : peek
   // one word into the fifo; valid stays up for a following push
   task automatic push(input logic [15:0] w);
      wdata_valid_i <= 1'b1;
      wdata_i <= w;
      wq.push_back(w);
      i = 0;
      do begin @(posedge clk_i); i++; end while (wdata_ready_o !== 1'b1 && i < 3000);
   endtask : push
   // one access; reads and rmw compare old data with unselected lanes zero
   task automatic do_op(input logic [1:0] c, input logic [17:0] a, input logic [1:0] ln);
      logic [15:0] m, e, w;
      m = {{8{ln[1]}}, {8{ln[0]}}};
      e = peek(a) & m;
      if (c != bladp_pkg::CMD_READ) begin
         w = wq.pop_front();
         exp_mem[a] = (peek(a) & ~m) | (w & m);
      end
      req_valid_i <= 1'b1;
      req_cmd_i <= c;
      req_addr_i <= a;
      req_lanes_i <= ln;
      i = 0;
      do begin @(posedge clk_i); i++; end while (req_ready_o !== 1'b1 && i < 3000);
      chk({15'h0000, req_ready_o}, 16'h0001);
      req_valid_i <= 1'b0;
      if (c != bladp_pkg::CMD_WRITE) begin
         i = 0;
         do begin @(posedge clk_i); i++; end while (rdata_valid_o !== 1'b1 && i < 100);
         chk({15'h0000, rdata_valid_o}, 16'h0001);
         chk(rdata_o, e);
      end
      @(posedge clk_i);
   endtask : do_op
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // main sequence: reset, fill and drain the fifo, then mixed traffic
   initial begin
      seed = 32'h2512;
      for (int k = 2; k < 8; k++) pool[k] = 18'($random(seed));
      pool[0] = 18'h00000; // boundary locations
      pool[1] = 18'h3FFFF;
      repeat (4) @(posedge clk_i);
      chk({10'h000, row_n, lcol_n, ucol_n, we_n, oe_n, dq_oe}, 16'h003E);
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      i = 0;
      while (init_done_o !== 1'b1 && i < 5000) begin @(posedge clk_i); i++; end
      chk({14'h0000, init_done_o, 1'(u_mem.refresh_count >= 8)}, 16'h0003);
      for (int k = 0; k < 32; k++) push(16'($random(seed)));
      wdata_valid_i <= 1'b0;
      @(posedge clk_i);
      chk({15'h0000, wdata_ready_o}, 16'h0000); // full fifo refuses
      for (int k = 0; k < 32; k++) do_op(bladp_pkg::CMD_WRITE, pool[k % 8], 2'(k % 3 + 1));
      for (int k = 0; k < 90; k++) begin
         cmd = 2'({$random(seed)} % 3);
         if (cmd != bladp_pkg::CMD_READ) begin
            push(16'($random(seed)));
            wdata_valid_i <= 1'b0;
         end
         do_op(cmd, pool[{$random(seed)} % 8], 2'({$random(seed)} % 3 + 1));
         if (k == 45) repeat (600) @(posedge clk_i); // idle stretch: refresh alone
      end
      summarize();
   end
   // watchdog well beyond the expected run
   initial begin
      repeat (60000) @(posedge clk_i);
      n_errors++;
      summarize();
   end
endmodule : byte_lane_async_dram_port_bench
`default_nettype wire
